//--- hw/wake_pkg.sv
// wake_pkg: constants for the wake output block
// assumes a 10 MHz core clock and an APB register slave with 32-bit words
package wake_pkg;
  // apb byte offsets
  localparam logic [7:0] OFF_FLAGS   = 8'h00;
  localparam logic [7:0] OFF_PIN_EN  = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;
  localparam logic [7:0] OFF_INT_STS = 8'h0C;
  localparam logic [7:0] OFF_INT_CLR = 8'h10;
  localparam logic [7:0] OFF_INT_EN  = 8'h14;
  localparam logic [7:0] OFF_CTRL    = 8'h18;
  // wake flag byte fields
  localparam int B_EN    = 7;
  localparam int B_PULSE = 6;
  localparam int B_LONG  = 5;
  localparam int B_POL   = 4;
  localparam int B_PUSH  = 3;
  localparam int B_LINK  = 2;
  localparam int B_DSENS = 1;
  // configuration memory
  localparam logic [7:0]  CFG_SIGNATURE  = 8'hA5;
  localparam logic [7:0]  FLAGS_DEFAULT  = 8'h00;
  localparam logic [10:0] PIN_EN_DEFAULT = 11'h000;
  localparam int          DED_PIN        = 10;
  // interrupt status bits
  localparam int IRQ_WAKE_ON  = 0;
  localparam int IRQ_WAKE_END = 1;
  localparam int IRQ_DEFAULTS = 2;
  localparam int IRQ_W        = 3;
  // status register bits
  localparam int ST_ACTIVE = 0;
  localparam int ST_EXTPHY = 1;
  localparam int ST_LOADED = 2;
  // control register bits
  localparam int CT_RELEASE = 0;
  // pulse timing
  localparam real CLK_PERIOD_NS  = 100.0;
  localparam real PULSE_SHORT_MS = 1.5;
  localparam real PULSE_LONG_MS  = 150.0;
  localparam int  SHORT_CYC = int'($ceil(PULSE_SHORT_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  LONG_CYC  = int'($ceil(PULSE_LONG_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  CNT_W     = 21;

  typedef enum logic [1:0] {W_IDLE, W_LEVEL, W_PULSE} wake_state_e;
endpackage : wake_pkg

//--- hw/wake_signal.sv
// wake_signal: wake output pin logic with apb registers and interrupt
// assumes all inputs synchronous to ref_clk; pins resolved outside from out/oe
`timescale 1ns/1ps

// Summary of operation
// - With flag bit 7 clear the wake pins are never asserted and all other flag bits are ignored.
// - The wake indication goes to the internal-PHY pin or the external-PHY pin per the PHY select.
// - Flag bit 6 chooses a steady level (0) or a single pulse (1).
// - In pulse form bit 5 picks 1.5 ms (0) or 150 ms (1), timed by a clock counter.
// - Flag bit 4 sets the asserted polarity, 0 low and 1 high, for both forms.
// - Bit 3 set drives both levels; clear drives only the asserted level (drain or source).
// - Bit 2 picks magic packet (0) or link-up (1); link-up is unusable with an external PHY.
// - Any wake pin enabled in the per-pin enable field, loaded from bytes 1Eh/1Fh, raises a wake.
// - The dedicated wake input is a source with either PHY; bit 1 sets its sense, 0 low, 1 high.
// - Flags load from memory only when the signature byte is valid, else defaults apply.
module wake_signal
  import wake_pkg::*;
#(
  parameter int unsigned SHORT_CYCLES = SHORT_CYC,
  parameter int unsigned LONG_CYCLES  = LONG_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cfg_load_valid,
  input  wire logic [7:0]  cfg_signature,
  input  wire logic [7:0]  cfg_wake_flags,
  input  wire logic [15:0] cfg_pin_enable,
  input  wire logic        phy_interface_select,
  input  wire logic        magic_packet_seen,
  input  wire logic        link_up_seen,
  input  wire logic [9:0]  wake_pins,
  input  wire logic        dedicated_wake_input,
  output logic             internal_phy_wake_pin_out,
  output logic             internal_phy_wake_pin_oe,
  output logic             external_phy_wake_pin_out,
  output logic             external_phy_wake_pin_oe,
  output logic             irq
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  wake_state_e          state_r, state_nxt;
  logic [7:0]           flags_r;
  logic [10:0]          pin_en_r;
  logic                 loaded_r;
  logic [CNT_W-1:0]     cnt_r, cnt_nxt;
  logic [10:0]          pins_prev_r;
  logic [IRQ_W-1:0]     int_sts_r, int_en_r, int_set;
  logic                 pready_r, pslverr_r, irq_r;
  logic [31:0]          prdata_r;
  logic                 int_out_r, int_oe_r, ext_out_r, ext_oe_r;

  // apb decode
  wire setup_ph = psel && !penable;
  wire wr_fire  = psel && penable && pwrite && pready_r;
  wire a_flags  = hit(paddr, OFF_FLAGS);
  wire a_pin_en = hit(paddr, OFF_PIN_EN);
  wire a_status = hit(paddr, OFF_STATUS);
  wire a_ists   = hit(paddr, OFF_INT_STS);
  wire a_iclr   = hit(paddr, OFF_INT_CLR);
  wire a_ien    = hit(paddr, OFF_INT_EN);
  wire a_ctrl   = hit(paddr, OFF_CTRL);
  wire mapped   = a_flags | a_pin_en | a_status | a_ists | a_iclr | a_ien | a_ctrl;
  wire wr_flags = wr_fire && a_flags;
  wire wr_pins  = wr_fire && a_pin_en;
  wire wr_iclr  = wr_fire && a_iclr;
  wire wr_ien   = wr_fire && a_ien;
  wire release_wr = wr_fire && a_ctrl && pwdata[CT_RELEASE];

  wire [31:0] status_word = {29'h0000_0000, loaded_r, phy_interface_select, state_r != W_IDLE};
  wire [31:0] rd_data =
      a_flags  ? {24'h00_0000, flags_r} :
      a_pin_en ? {21'h00_0000, pin_en_r} :
      a_status ? status_word :
      a_ists   ? {29'h0000_0000, int_sts_r} :
      a_ien    ? {29'h0000_0000, int_en_r} : 32'h0000_0000;

  // configuration load
  wire sig_ok    = (cfg_signature == CFG_SIGNATURE);
  wire cfg_chg   = cfg_load_valid || wr_flags;
  wire [7:0]  flags_ld  = sig_ok ? cfg_wake_flags : FLAGS_DEFAULT;
  wire [10:0] pin_en_ld = sig_ok ? cfg_pin_enable[10:0] : PIN_EN_DEFAULT;

  // flag fields; bit 0 is not decoded
  wire f_en    = flags_r[B_EN];
  wire f_pulse = flags_r[B_PULSE];
  wire f_long  = flags_r[B_LONG];
  wire f_pol   = flags_r[B_POL];
  wire f_push  = flags_r[B_PUSH];
  wire f_link  = flags_r[B_LINK];
  wire f_dsens = flags_r[B_DSENS];

  // event sources
  wire ded_act  = (dedicated_wake_input == f_dsens);
  wire [10:0] pins_act = {ded_act, wake_pins};
  wire [10:0] pins_rise = pins_act & ~pins_prev_r & pin_en_r;
  wire ded_hit  = pins_rise[DED_PIN];
  wire pin_hit  = |pins_rise;
  wire link_ok  = f_link && !phy_interface_select && link_up_seen;
  wire magic_ok = !f_link && magic_packet_seen;
  wire net_hit  = link_ok || magic_ok;
  wire event_hit = f_en && (net_hit || pin_hit);
  wire active   = (state_r != W_IDLE);

  wire [CNT_W-1:0] cnt_load = f_long ? CNT_W'(LONG_CYCLES - 1)
                                     : CNT_W'(SHORT_CYCLES - 1);

  // wake state machine
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      W_IDLE: begin
        if (event_hit && !cfg_chg) begin
          state_nxt = f_pulse ? W_PULSE : W_LEVEL;
          cnt_nxt   = cnt_load;
        end
      end
      W_LEVEL: begin
        if (!f_en || cfg_chg || release_wr) begin
          state_nxt = W_IDLE;
        end
      end
      W_PULSE: begin
        if (!f_en || cfg_chg || cnt_r == '0) begin
          state_nxt = W_IDLE;
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
    endcase
  end

  // pin drive: level is asserted polarity while active, else its inverse
  wire nxt_on    = (state_nxt != W_IDLE);
  wire [7:0] flags_nxt = cfg_load_valid ? flags_ld : (wr_flags ? pwdata[7:0] : flags_r);
  wire n_en      = flags_nxt[B_EN];
  wire n_pol     = flags_nxt[B_POL];
  wire pin_level = nxt_on ? n_pol : !n_pol;
  wire pin_drive = n_en && (flags_nxt[B_PUSH] || nxt_on);

  // interrupt events
  always_comb begin
    int_set               = '0;
    int_set[IRQ_WAKE_ON]  = (state_r == W_IDLE) && nxt_on;
    int_set[IRQ_WAKE_END] = active && !nxt_on;
    int_set[IRQ_DEFAULTS] = cfg_load_valid && !sig_ok;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_r     <= W_IDLE;
      cnt_r       <= '0;
      pins_prev_r <= '0;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      pins_prev_r <= pins_act;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      flags_r  <= FLAGS_DEFAULT;
      pin_en_r <= PIN_EN_DEFAULT;
      loaded_r <= 1'b0;
    end else begin
      flags_r  <= flags_nxt;
      if (cfg_load_valid) begin
        pin_en_r <= pin_en_ld;
        loaded_r <= sig_ok;
      end else if (wr_pins) begin
        pin_en_r <= pwdata[10:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      int_out_r <= 1'b1;
      int_oe_r  <= 1'b0;
      ext_out_r <= 1'b1;
      ext_oe_r  <= 1'b0;
    end else begin
      int_out_r <= pin_level;
      ext_out_r <= pin_level;
      int_oe_r  <= pin_drive && !phy_interface_select;
      ext_oe_r  <= pin_drive && phy_interface_select;
    end
  end

  // apb slave and interrupt registers; set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      int_sts_r <= '0;
      int_en_r  <= '0;
      irq_r     <= 1'b0;
    end else begin
      pready_r  <= setup_ph;
      pslverr_r <= setup_ph && !mapped;
      prdata_r  <= (setup_ph && !pwrite) ? rd_data : 32'h0000_0000;
      int_sts_r <= (int_sts_r & ~(wr_iclr ? pwdata[IRQ_W-1:0] : '0)) | int_set;
      if (wr_ien) begin
        int_en_r <= pwdata[IRQ_W-1:0];
      end
      irq_r     <= |(int_sts_r & int_en_r);
    end
  end

  assign prdata                    = prdata_r;
  assign pready                    = pready_r;
  assign pslverr                   = pslverr_r;
  assign irq                       = irq_r;
  assign internal_phy_wake_pin_out = int_out_r;
  assign internal_phy_wake_pin_oe  = int_oe_r;
  assign external_phy_wake_pin_out = ext_out_r;
  assign external_phy_wake_pin_oe  = ext_oe_r;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  master_off_a: assert property (
    (!f_en && !cfg_chg) |=> !int_oe_r && !ext_oe_r && !active)
    else $error("wake pin driven while master enable clear");
  pin_route_a: assert property (
    $past(phy_interface_select) |-> !int_oe_r)
    else $error("internal pin driven with external phy");
  level_hold_a: assert property (
    (state_r == W_LEVEL && f_en && !cfg_chg && !release_wr) |=> state_r == W_LEVEL)
    else $error("level wake dropped without cause");
  pulse_len_a: assert property (
    (state_r == W_IDLE && state_nxt == W_PULSE) |=>
      cnt_r == ($past(f_long) ? CNT_W'(LONG_CYCLES - 1) : CNT_W'(SHORT_CYCLES - 1)))
    else $error("pulse length loaded wrong");
  polarity_a: assert property (
    (active && !cfg_chg && state_nxt != W_IDLE) |=> int_out_r == $past(f_pol))
    else $error("asserted pin level wrong polarity");
  driver_style_a: assert property (
    (f_en && !f_push && state_nxt == W_IDLE && !cfg_chg) |=> !int_oe_r && !ext_oe_r)
    else $error("open drain or source pin driven while idle");
  link_ext_a: assert property (
    (state_r == W_IDLE && phy_interface_select && f_link && !pin_hit) |=> !active)
    else $error("link-up wake taken with external phy");
  pin_wake_a: assert property (
    (f_en && state_r == W_IDLE && pin_hit && !cfg_chg) |=> active)
    else $error("enabled wake pin ignored");
  ded_sense_a: assert property (
    ded_hit |-> dedicated_wake_input == f_dsens)
    else $error("dedicated input detected with wrong sense");
  sig_check_a: assert property (
    (cfg_load_valid && !sig_ok) |=> flags_r == FLAGS_DEFAULT && !loaded_r)
    else $error("flags loaded without valid signature");
  one_pulse_a: assert property (
    (state_r == W_PULSE && cnt_r == '0) |=>
      state_r == W_IDLE ##1 (state_r == W_IDLE || $past(event_hit)))
    else $error("pulse did not end or retriggered at once");

  level_c: cover property (state_r == W_IDLE ##1 state_r == W_LEVEL);
  pulse_c: cover property (state_r == W_PULSE && cnt_r == '0);
  irq_c:   cover property (irq_r && wr_iclr);
  ext_c:   cover property (ext_oe_r && active);

endmodule : wake_signal

//--- verification/wake_host_model.sv
// wake_host_model: host end of the wake pin, resolves the wire and times pulses
// assumes a pull resistor toward the idle level given by pol
`timescale 1ns/1ps
module wake_host_model (
  input  wire logic ref_clk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic pol,
  output logic      level,
  output int        pulses,
  output int        last_len
);
  int run;

  // undriven wire rests at the idle level through the pull
  assign level = pin_oe ? pin_out : !pol;

  initial begin
    run = 0;
    pulses = 0;
    last_len = 0;
  end

  // counts asserted cycles, books one pulse when the line goes idle
  always @(posedge ref_clk) begin
    if (level === pol) begin
      run <= run + 1;
    end else begin
      if (run > 0) begin
        pulses   <= pulses + 1;
        last_len <= run;
      end
      run <= 0;
    end
  end
endmodule : wake_host_model

//--- verification/wake_event_signaling_test.sv
// wake_event_signaling_test: corner and random wake cases on wake_signal
// assumes zero-wait apb slave; host model watches the selected wake pin
`timescale 1ns/1ps
module wake_event_signaling_test;
  import wake_pkg::*;
  localparam int SHORT = 5;
  localparam int LONG  = 20;
  logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr, e, cfg_load_valid;
  logic [7:0]  paddr, cfg_signature, cfg_wake_flags;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] cfg_pin_enable;
  logic [9:0]  wake_pins;
  logic        phy_interface_select, magic_packet_seen, link_up_seen, dedicated_wake_input;
  logic        int_out, int_oe, ext_out, ext_oe, irq, pol, level;
  int          err_count, samples_checked, pulses, last_len;
  logic [7:0]  corner [4] = '{8'h7F, 8'hC4, 8'hE8, 8'h9A};

  wake_signal #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) dut (
    .ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cfg_load_valid, .cfg_signature, .cfg_wake_flags, .cfg_pin_enable,
    .phy_interface_select, .magic_packet_seen, .link_up_seen, .wake_pins,
    .dedicated_wake_input, .internal_phy_wake_pin_out(int_out),
    .internal_phy_wake_pin_oe(int_oe), .external_phy_wake_pin_out(ext_out),
    .external_phy_wake_pin_oe(ext_oe), .irq);

  wake_host_model host (.ref_clk, .pin_out(phy_interface_select ? ext_out : int_out),
    .pin_oe(phy_interface_select ? ext_oe : int_oe), .pol, .level, .pulses, .last_len);

  always #50 ref_clk = ~ref_clk;

  task close_out;
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      err_count++;
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      close_out();
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask : apb

  task load(input logic [7:0] s, input logic [7:0] f);
    cfg_signature <= s;
    cfg_wake_flags <= f;
    cfg_pin_enable <= 16'hF408;
    cfg_load_valid <= 1;
    @(posedge ref_clk);
    cfg_load_valid <= 0;
    @(posedge ref_clk);
  endtask : load

  task run_case(input logic [7:0] f, input logic phy, input int src);
    logic fire;
    int   p0, n;
    phy_interface_select <= phy;
    pol <= f[4];
    dedicated_wake_input <= !f[1];
    wake_pins <= 0;
    @(posedge ref_clk);
    apb(1, OFF_FLAGS, {24'h0, f});
    @(posedge ref_clk);
    p0 = pulses;
    fire = f[7] && (src == 0 ? !f[2] : src == 1 ? (f[2] && !phy) : 1'b1);
    case (src)
      0: magic_packet_seen <= 1;
      1: link_up_seen <= 1;
      2: dedicated_wake_input <= f[1];
      default: wake_pins <= 10'h008;
    endcase
    @(posedge ref_clk);
    magic_packet_seen <= 0;
    link_up_seen <= 0;
    @(posedge ref_clk);
    chk(phy ? ext_oe : int_oe, f[7] && (f[3] || fire));
    chk(phy ? int_oe : ext_oe, 0);
    if (fire) chk(phy ? ext_out : int_out, f[4]);
    if (!fire) begin
      repeat (25) @(posedge ref_clk);
      chk(pulses - p0, 0);
    end else if (f[6]) begin
      n = 0;
      while (pulses == p0 && n < LONG + 20) begin
        @(posedge ref_clk);
        n++;
      end
      if (pulses == p0) begin
        err_count++;
        close_out();
      end
      chk(last_len, f[5] ? LONG : SHORT);
      repeat (5) @(posedge ref_clk);
      chk(pulses - p0, 1);
    end else begin
      repeat (30) @(posedge ref_clk);
      chk(level, f[4]);
      apb(1, OFF_CTRL, 1);
      repeat (3) @(posedge ref_clk);
      chk(level, !f[4]);
    end
    $display("case flags=%h phy=%0d src=%0d done", f, phy, src);
  endtask : run_case

  initial begin
    ref_clk = 0; rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    cfg_load_valid = 0; cfg_signature = 0; cfg_wake_flags = 0; cfg_pin_enable = 0;
    phy_interface_select = 0; magic_packet_seen = 0; link_up_seen = 0; wake_pins = 0;
    dedicated_wake_input = 1; pol = 0; err_count = 0; samples_checked = 0;
    q = $urandom(32'h14FB);
    repeat (5) @(posedge ref_clk);
    rstn <= 1;
    @(posedge ref_clk);
    apb(0, 8'h40, 32'h0);
    chk({e, q[30:0]}, 32'h8000_0000);
    apb(1, OFF_INT_EN, 32'h1);
    load(8'h5A, 8'hD0);
    apb(0, OFF_FLAGS, 32'h0);
    chk(q, 32'h0);
    apb(0, OFF_INT_STS, 32'h0);
    chk({q[31:1], irq}, 32'h4);
    load(CFG_SIGNATURE, 8'hD0);
    apb(0, OFF_FLAGS, 32'h0);
    chk(q, 32'hD0);
    apb(0, OFF_PIN_EN, 32'h0);
    chk(q, 32'h408);
    apb(0, OFF_STATUS, 32'h0);
    chk(q, 32'h4);
    apb(1, OFF_INT_CLR, 32'h7);
    pol <= 1;
    magic_packet_seen <= 1;
    @(posedge ref_clk);
    magic_packet_seen <= 0;
    repeat (3) @(posedge ref_clk);
    chk(irq, 1);
    apb(1, OFF_INT_EN, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk(irq, 0);
    apb(1, OFF_INT_CLR, 32'h7);
    apb(1, OFF_INT_EN, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(irq, 0);
    $display("register and interrupt test done");
    for (int i = 0; i < 4; i++) run_case(corner[i], i == 1, i);
    for (int i = 0; i < 24; i++) run_case(8'($urandom), 1'($urandom), int'($urandom % 4));
    close_out();
  end
endmodule : wake_event_signaling_test
